/* File: fms_regs.svh */
// Register offsets, field positions, reset values and timing for the clock generator.
`ifndef FMS_REGS_SVH
`define FMS_REGS_SVH

// ---------------------------------------------------------------------------
// Register byte offsets
// ---------------------------------------------------------------------------
`define FMS_ADDR_SRC_CTRL     8'h00
`define FMS_ADDR_OSC_CTRL     8'h04
`define FMS_ADDR_STATUS       8'h08
`define FMS_ADDR_RANGE_CTRL   8'h0C
`define FMS_ADDR_COARSE_TRIM  8'h10

// ---------------------------------------------------------------------------
// Field positions
// ---------------------------------------------------------------------------
`define FMS_SRC_SEL_HI        7
`define FMS_SRC_SEL_LO        6
`define FMS_REF_DIV_HI        5
`define FMS_REF_DIV_LO        3
`define FMS_INT_REF_SEL       2
`define FMS_BUS_DIV_HI        7
`define FMS_BUS_DIV_LO        6
`define FMS_OSC_RANGE         5
`define FMS_HIGH_GAIN         4
`define FMS_LOW_POWER         3
`define FMS_EXT_SRC_SEL       2
`define FMS_EXT_CLK_EN        1
`define FMS_ST_LOCK           6
`define FMS_ST_INT_REF        4
`define FMS_ST_SRC_HI         3
`define FMS_ST_SRC_LO         2
`define FMS_ST_OSC_READY      1
`define FMS_ST_FINE_TRIM      0
`define FMS_FINE_RANGE        5
`define FMS_FLL_RANGE         0

// ---------------------------------------------------------------------------
// Codes and reset values
// ---------------------------------------------------------------------------
`define FMS_CODE_FLL          2'h0
`define FMS_CODE_INT          2'h1
`define FMS_CODE_EXT          2'h2
`define FMS_SRC_CTRL_RESET    8'h04
`define FMS_OSC_CTRL_RESET    8'h40
`define FMS_RANGE_CTRL_RESET  8'h01
`define FMS_TRIM_IDLE         9'h100
`define FMS_TRIM_DEBUG        12'h800
`define FMS_FACTOR_HIGH       11'h400
`define FMS_FACTOR_LOW        11'h200
`define FMS_FACTOR_BYPASS     11'h001
`define FMS_RESP_OKAY         2'h0
`define FMS_RESP_SLVERR       2'h2

// ---------------------------------------------------------------------------
// Timing
// ---------------------------------------------------------------------------
`define FMS_CLOCK_MHZ         25
`define FMS_OSC_START_US      1000
`define FMS_LOCK_TIME_US      10
`define FMS_REF_SWITCH_CYC    4'h3
`define FMS_SRC_SWITCH_CYC    4'h4

`endif

/* File: fms_pkg.sv */
// Types shared by the clock generator files.
package fms_pkg;

   typedef enum logic [1:0] {
      SW_IDLE,
      SW_SETTLE,
      SW_COMMIT
   } fms_switch_state_t;

   typedef enum logic [2:0] {
      MODE_FLL_ENG_INT,
      MODE_FLL_ENG_EXT,
      MODE_FLL_BYP_INT,
      MODE_FLL_BYP_EXT,
      MODE_LOWPWR_INT,
      MODE_LOWPWR_EXT
   } fms_mode_t;

endpackage : fms_pkg

/* File: fms_settle_timer.sv */
// Down counter that reports when a settling interval has elapsed.
`timescale 1ns/1ps

module fms_settle_timer #(
   parameter int unsigned WIDTH = 16,
   parameter logic [WIDTH-1:0] COUNT = '1
) (
   // Clock and reset
   input  wire logic  clock,
   input  wire logic  reset,
   // Control
   input  wire logic  enable,
   input  wire logic  restart,
   // Status
   output logic       done
);

   logic [WIDTH-1:0]  count_ff;

   always_ff @(posedge clock or posedge reset) begin
      if (reset) begin
         count_ff <= COUNT;
         done     <= 1'b0;
      end else if (!enable || restart) begin
         count_ff <= COUNT;
         done     <= 1'b0;
      end else if (count_ff != '0) begin
         count_ff <= count_ff - 1'b1;
      end else begin
         done     <= 1'b1;
      end
   end

endmodule : fms_settle_timer

/* File: fms_clock_gen.sv */
// Clock generator mode switch, FLL range and reference trim with AXI4-Lite.
// Contract
// - FLL keeps running while bypassed internally; lock flag sets when locked.
// - Oscillator-ready sets after crystal startup; software waits before switching.
// - Internal-reference status clears once external reference feeds the FLL.
// - Clock status reads 00 when the FLL drives the generator output.
// - Engaged output is reference times 1024 divided by output divider.
// - Range select resets to 1, fine range to 0; clearing halves factor.
// - Trim is nine bits: coarse register high, fine bit lowest.
// - Reset loads factory trim, or 0x000 (0x800 cut to nine bits) when entering background debug.
// - Larger trim lowers reference frequency; smaller trim raises it.
// - Bus clock equals generator output divided by two.
`timescale 1ns/1ps
`include "fms_regs.svh"

module fms_clock_gen #(
   parameter int unsigned OSC_START_CYCLES =
      `FMS_OSC_START_US * `FMS_CLOCK_MHZ
) (
   // Clock and reset
   input  wire logic               clock,
   input  wire logic               reset,
   // Reset straps
   input  wire logic               debugEntryPin,
   input  wire logic [8:0]         factoryTrim,
   // AXI4-Lite write address
   input  wire logic               s_axi_awvalid,
   output logic                    s_axi_awready,
   input  wire logic [7:0]         s_axi_awaddr,
   // AXI4-Lite write data
   input  wire logic               s_axi_wvalid,
   output logic                    s_axi_wready,
   input  wire logic [31:0]        s_axi_wdata,
   input  wire logic [3:0]         s_axi_wstrb,
   // AXI4-Lite write response
   output logic                    s_axi_bvalid,
   input  wire logic               s_axi_bready,
   output logic [1:0]              s_axi_bresp,
   // AXI4-Lite read address
   input  wire logic               s_axi_arvalid,
   output logic                    s_axi_arready,
   input  wire logic [7:0]         s_axi_araddr,
   // AXI4-Lite read data
   output logic                    s_axi_rvalid,
   input  wire logic               s_axi_rready,
   output logic [31:0]             s_axi_rdata,
   output logic [1:0]              s_axi_rresp,
   // Generator settings
   output logic [8:0]              trimValue_ff,
   output logic [10:0]             outMultiplier_ff,
   output logic [3:0]              outDivider_ff,
   output logic [4:0]              busDivider_ff,
   output fms_pkg::fms_mode_t      mode_ff
);

   localparam int unsigned LOCK_CYCLES_I =
      `FMS_LOCK_TIME_US * `FMS_CLOCK_MHZ;
   localparam logic [15:0] OSC_CYCLES  = 16'(OSC_START_CYCLES);
   localparam logic [15:0] LOCK_CYCLES = 16'(LOCK_CYCLES_I);

   // ------------------------------------------------------------------------
   // Registers
   // ------------------------------------------------------------------------
   logic [7:0]  srcCtrl_ff;
   logic [7:0]  oscCtrl_ff;
   logic [7:0]  rangeCtrl_ff;
   logic [7:0]  coarseTrim_ff;
   logic        fineTrim_ff;
   logic        oscReady;
   logic        fllLocked;
   logic        intRefStatus_ff;
   logic [1:0]  srcStatus_ff;

   logic        awHeld_ff;
   logic [7:0]  awAddr_ff;
   logic        wHeld_ff;
   logic [31:0] wData_ff;
   logic [3:0]  wStrb_ff;
   logic        doWrite;
   logic        wrHit;

   assign doWrite = awHeld_ff && wHeld_ff && !s_axi_bvalid;

   always_comb begin
      case (awAddr_ff)
         `FMS_ADDR_SRC_CTRL,
         `FMS_ADDR_OSC_CTRL,
         `FMS_ADDR_STATUS,
         `FMS_ADDR_RANGE_CTRL,
         `FMS_ADDR_COARSE_TRIM: wrHit = 1'b1;
         default:               wrHit = 1'b0;
      endcase
   end

   // ------------------------------------------------------------------------
   // AXI4-Lite write channels
   // ------------------------------------------------------------------------
   // Address and data are caught independently, so either may come first.
   always_ff @(posedge clock or posedge reset) begin
      if (reset) begin
         awHeld_ff     <= 1'b0;
         awAddr_ff     <= 8'h00;
         s_axi_awready <= 1'b1;
      end else if (s_axi_awvalid && s_axi_awready) begin
         awHeld_ff     <= 1'b1;
         awAddr_ff     <= s_axi_awaddr;
         s_axi_awready <= 1'b0;
      end else if (doWrite) begin
         awHeld_ff     <= 1'b0;
      end else if (!awHeld_ff && !s_axi_bvalid) begin
         s_axi_awready <= 1'b1;
      end
   end

   always_ff @(posedge clock or posedge reset) begin
      if (reset) begin
         wHeld_ff     <= 1'b0;
         wData_ff     <= 32'h0000_0000;
         wStrb_ff     <= 4'h0;
         s_axi_wready <= 1'b1;
      end else if (s_axi_wvalid && s_axi_wready) begin
         wHeld_ff     <= 1'b1;
         wData_ff     <= s_axi_wdata;
         wStrb_ff     <= s_axi_wstrb;
         s_axi_wready <= 1'b0;
      end else if (doWrite) begin
         wHeld_ff     <= 1'b0;
      end else if (!wHeld_ff && !s_axi_bvalid) begin
         s_axi_wready <= 1'b1;
      end
   end

   always_ff @(posedge clock or posedge reset) begin
      if (reset) begin
         s_axi_bvalid <= 1'b0;
         s_axi_bresp  <= `FMS_RESP_OKAY;
      end else if (doWrite) begin
         s_axi_bvalid <= 1'b1;
         s_axi_bresp  <= wrHit ? `FMS_RESP_OKAY : `FMS_RESP_SLVERR;
      end else if (s_axi_bready) begin
         s_axi_bvalid <= 1'b0;
      end
   end

   // ------------------------------------------------------------------------
   // Control registers
   // ------------------------------------------------------------------------
   logic wrLow;

   assign wrLow = doWrite && wStrb_ff[0];

   always_ff @(posedge clock or posedge reset) begin
      if (reset) begin
         srcCtrl_ff   <= `FMS_SRC_CTRL_RESET;
         oscCtrl_ff   <= `FMS_OSC_CTRL_RESET;
         rangeCtrl_ff <= `FMS_RANGE_CTRL_RESET;
      end else if (wrLow) begin
         if (awAddr_ff == `FMS_ADDR_SRC_CTRL)
            srcCtrl_ff <= wData_ff[7:0];
         if (awAddr_ff == `FMS_ADDR_OSC_CTRL)
            oscCtrl_ff <= wData_ff[7:0];
         if (awAddr_ff == `FMS_ADDR_RANGE_CTRL)
            rangeCtrl_ff <= wData_ff[7:0];
      end
   end

   // ------------------------------------------------------------------------
   // Reference trim
   // ------------------------------------------------------------------------
   // The debug strap is a pin, so it is synchronised and the trim strap is
   // taken on the third edge after release, once the synchronised level is valid.
   localparam logic [8:0] TRIM_DEBUG_9 = 9'(`FMS_TRIM_DEBUG);
   localparam logic [8:0] TRIM_IDLE_9  = `FMS_TRIM_IDLE;
   logic       debugSync1_ff;
   logic       debugSync2_ff;
   logic [1:0] loadWait_ff;
   logic       loadDone_ff;

   always_ff @(posedge clock or posedge reset) begin
      if (reset) begin
         debugSync1_ff <= 1'b0;
         debugSync2_ff <= 1'b0;
      end else begin
         debugSync1_ff <= debugEntryPin;
         debugSync2_ff <= debugSync1_ff;
      end
   end

   always_ff @(posedge clock or posedge reset) begin
      if (reset) begin
         loadWait_ff <= 2'h0;
         loadDone_ff <= 1'b0;
      end else if (loadWait_ff != 2'h2) begin
         loadWait_ff <= loadWait_ff + 2'h1;
      end else begin
         loadDone_ff <= 1'b1;
      end
   end

   always_ff @(posedge clock or posedge reset) begin
      if (reset) begin
         coarseTrim_ff <= TRIM_IDLE_9[8:1];
         fineTrim_ff   <= 1'b0;
      end else if (!loadDone_ff && loadWait_ff == 2'h2) begin
         if (debugSync2_ff) begin
            coarseTrim_ff <= TRIM_DEBUG_9[8:1];
            fineTrim_ff   <= TRIM_DEBUG_9[0];
         end else begin
            coarseTrim_ff <= factoryTrim[8:1];
            fineTrim_ff   <= factoryTrim[0];
         end
      end else if (wrLow) begin
         if (awAddr_ff == `FMS_ADDR_COARSE_TRIM)
            coarseTrim_ff <= wData_ff[7:0];
         if (awAddr_ff == `FMS_ADDR_STATUS)
            fineTrim_ff <= wData_ff[`FMS_ST_FINE_TRIM];
      end
   end

   // Trim reaches the oscillator directly; a larger code gives a longer
   // reference period, which is what iterative search software expects.
   always_ff @(posedge clock or posedge reset) begin
      if (reset) begin
         trimValue_ff <= `FMS_TRIM_IDLE;
      end else begin
         trimValue_ff <= {coarseTrim_ff, fineTrim_ff};
      end
   end

   // ------------------------------------------------------------------------
   // Oscillator startup and FLL lock
   // ------------------------------------------------------------------------
   logic oscEnable;
   logic extRefWanted;
   logic fllRunning;
   logic lockRestart;
   logic [8:0] lastTrim_ff;
   logic [7:0] lastRange_ff;
   logic [2:0] lastDiv_ff;
   logic       lastRef_ff;

   assign extRefWanted = !srcCtrl_ff[`FMS_INT_REF_SEL];
   assign oscEnable    = oscCtrl_ff[`FMS_EXT_SRC_SEL] &&
                         (oscCtrl_ff[`FMS_EXT_CLK_EN] || extRefWanted);
   // The FLL only stops in a low-power bypassed mode.
   assign fllRunning   = !(oscCtrl_ff[`FMS_LOW_POWER] &&
                           srcStatus_ff != `FMS_CODE_FLL);
   // Any change of the loop's reference or factor throws lock away.
   assign lockRestart  = lastTrim_ff != trimValue_ff ||
                         lastRange_ff != rangeCtrl_ff ||
                         lastDiv_ff !=
                            srcCtrl_ff[`FMS_REF_DIV_HI:`FMS_REF_DIV_LO] ||
                         lastRef_ff != intRefStatus_ff;

   always_ff @(posedge clock or posedge reset) begin
      if (reset) begin
         lastTrim_ff  <= `FMS_TRIM_IDLE;
         lastRange_ff <= `FMS_RANGE_CTRL_RESET;
         lastDiv_ff   <= 3'h0;
         lastRef_ff   <= 1'b1;
      end else begin
         lastTrim_ff  <= trimValue_ff;
         lastRange_ff <= rangeCtrl_ff;
         lastDiv_ff   <= srcCtrl_ff[`FMS_REF_DIV_HI:`FMS_REF_DIV_LO];
         lastRef_ff   <= intRefStatus_ff;
      end
   end

   fms_settle_timer #(
      .WIDTH   (16),
      .COUNT   (OSC_CYCLES)
   ) oscTimer (
      .clock   (clock),
      .reset   (reset),
      .enable  (oscEnable),
      .restart (1'b0),
      .done    (oscReady)
   );

   fms_settle_timer #(
      .WIDTH   (16),
      .COUNT   (LOCK_CYCLES)
   ) lockTimer (
      .clock   (clock),
      .reset   (reset),
      .enable  (fllRunning),
      .restart (lockRestart),
      .done    (fllLocked)
   );

   // ------------------------------------------------------------------------
   // Reference and output source switching
   // ------------------------------------------------------------------------
   fms_pkg::fms_switch_state_t swState_ff;
   logic [3:0] swCount_ff;
   logic [3:0] refCount_ff;
   logic [1:0] srcWanted;
   logic       srcAllowed;

   assign srcWanted  = srcCtrl_ff[`FMS_SRC_SEL_HI:`FMS_SRC_SEL_LO];
   assign srcAllowed = srcWanted != `FMS_CODE_EXT || oscReady;

   // External reference takes over only after the crystal has started.
   always_ff @(posedge clock or posedge reset) begin
      if (reset) begin
         intRefStatus_ff <= 1'b1;
         refCount_ff     <= 4'h0;
      end else if (intRefStatus_ff == !extRefWanted ||
                   (extRefWanted && !oscReady)) begin
         refCount_ff     <= 4'h0;
      end else if (refCount_ff != `FMS_REF_SWITCH_CYC) begin
         refCount_ff     <= refCount_ff + 4'h1;
      end else begin
         intRefStatus_ff <= !extRefWanted;
         refCount_ff     <= 4'h0;
      end
   end

   always_ff @(posedge clock or posedge reset) begin
      if (reset) begin
         swState_ff   <= fms_pkg::SW_IDLE;
         swCount_ff   <= 4'h0;
         srcStatus_ff <= `FMS_CODE_FLL;
      end else begin
         case (swState_ff)
            fms_pkg::SW_IDLE: begin
               swCount_ff <= 4'h0;
               if (srcWanted != srcStatus_ff && srcAllowed &&
                   srcWanted != 2'h3)
                  swState_ff <= fms_pkg::SW_SETTLE;
            end
            fms_pkg::SW_SETTLE: begin
               if (srcWanted == srcStatus_ff || !srcAllowed)
                  swState_ff <= fms_pkg::SW_IDLE;
               else if (swCount_ff == `FMS_SRC_SWITCH_CYC)
                  swState_ff <= fms_pkg::SW_COMMIT;
               else
                  swCount_ff <= swCount_ff + 4'h1;
            end
            fms_pkg::SW_COMMIT: begin
               srcStatus_ff <= srcWanted;
               swState_ff   <= fms_pkg::SW_IDLE;
            end
            default: begin
               swState_ff   <= fms_pkg::SW_IDLE;
            end
         endcase
      end
   end

   // ------------------------------------------------------------------------
   // Output frequency relation and mode
   // ------------------------------------------------------------------------
   logic [1:0] busSel;

   assign busSel = oscCtrl_ff[`FMS_BUS_DIV_HI:`FMS_BUS_DIV_LO];

   always_ff @(posedge clock or posedge reset) begin
      if (reset) begin
         outMultiplier_ff <= `FMS_FACTOR_HIGH;
         outDivider_ff    <= 4'h1;
         busDivider_ff    <= 5'h02;
      end else begin
         if (srcStatus_ff != `FMS_CODE_FLL)
            outMultiplier_ff <= `FMS_FACTOR_BYPASS;
         else if (rangeCtrl_ff[`FMS_FLL_RANGE])
            outMultiplier_ff <= `FMS_FACTOR_HIGH;
         else
            outMultiplier_ff <= `FMS_FACTOR_LOW;
         outDivider_ff <= 4'h1 << busSel;
         busDivider_ff <= 5'h02 << busSel;
      end
   end

   always_ff @(posedge clock or posedge reset) begin
      if (reset) begin
         mode_ff <= fms_pkg::MODE_FLL_ENG_INT;
      end else if (srcStatus_ff == `FMS_CODE_FLL) begin
         mode_ff <= intRefStatus_ff ? fms_pkg::MODE_FLL_ENG_INT
                                    : fms_pkg::MODE_FLL_ENG_EXT;
      end else if (srcStatus_ff == `FMS_CODE_INT) begin
         mode_ff <= oscCtrl_ff[`FMS_LOW_POWER] ? fms_pkg::MODE_LOWPWR_INT
                                               : fms_pkg::MODE_FLL_BYP_INT;
      end else begin
         mode_ff <= oscCtrl_ff[`FMS_LOW_POWER] ? fms_pkg::MODE_LOWPWR_EXT
                                               : fms_pkg::MODE_FLL_BYP_EXT;
      end
   end

   // ------------------------------------------------------------------------
   // AXI4-Lite read channel
   // ------------------------------------------------------------------------
   logic [7:0] statusByte;
   logic [7:0] rdByte;
   logic       rdHit;

   assign statusByte = {1'b0, fllLocked, 1'b0, intRefStatus_ff,
                        srcStatus_ff, oscReady, fineTrim_ff};

   always_comb begin
      rdHit  = 1'b1;
      rdByte = 8'h00;
      case (s_axi_araddr)
         `FMS_ADDR_SRC_CTRL:    rdByte = srcCtrl_ff;
         `FMS_ADDR_OSC_CTRL:    rdByte = oscCtrl_ff;
         `FMS_ADDR_STATUS:      rdByte = statusByte;
         `FMS_ADDR_RANGE_CTRL:  rdByte = rangeCtrl_ff;
         `FMS_ADDR_COARSE_TRIM: rdByte = coarseTrim_ff;
         default:               rdHit  = 1'b0;
      endcase
   end

   always_ff @(posedge clock or posedge reset) begin
      if (reset) begin
         s_axi_arready <= 1'b1;
         s_axi_rvalid  <= 1'b0;
         s_axi_rdata   <= 32'h0000_0000;
         s_axi_rresp   <= `FMS_RESP_OKAY;
      end else if (s_axi_arvalid && s_axi_arready) begin
         s_axi_arready <= 1'b0;
         s_axi_rvalid  <= 1'b1;
         s_axi_rdata   <= {24'h00_0000, rdByte};
         s_axi_rresp   <= rdHit ? `FMS_RESP_OKAY : `FMS_RESP_SLVERR;
      end else if (s_axi_rvalid && s_axi_rready) begin
         s_axi_rvalid  <= 1'b0;
         s_axi_arready <= 1'b1;
      end
   end

endmodule : fms_clock_gen

/* File: fms_clock_gen_asserts.sv */
// Port assertions for the clock generator.
`timescale 1ns/1ps

module fms_clock_gen_asserts (
   // Clock, reset and straps
   input wire logic               clock,
   input wire logic               reset,
   input wire logic               debugEntryPin,
   input wire logic [8:0]         factoryTrim,
   // Read channel
   input wire logic               s_axi_arready,
   input wire logic               s_axi_rvalid,
   input wire logic [31:0]        s_axi_rdata,
   // Generator settings
   input wire logic [8:0]         trimValue_ff,
   input wire logic [10:0]        outMultiplier_ff,
   input wire logic [3:0]         outDivider_ff,
   input wire logic [4:0]         busDivider_ff,
   input wire fms_pkg::fms_mode_t mode_ff
);
   default clocking cb @(posedge clock);
   endclocking
   default disable iff (reset);

   // The strap is loaded a few edges after release, so look one edge late.
   sequence s_boot;
      $fell(reset) ##5 1'b1;
   endsequence
   sequence s_byp;
      (mode_ff == fms_pkg::MODE_FLL_BYP_INT) [*3];
   endsequence
   sequence s_eng;
      (mode_ff == fms_pkg::MODE_FLL_ENG_EXT) [*3];
   endsequence

   chk_boot_trim: assert property (
      s_boot |-> trimValue_ff == (debugEntryPin ? 9'h000 : factoryTrim))
      else $error("trim not taken from strap");
   chk_bus_half: assert property (
      $stable(outDivider_ff) |=> busDivider_ff == {outDivider_ff, 1'b0})
      else $error("bus divider not twice output divider");
   chk_div_power: assert property (
      $onehot(outDivider_ff)) else $error("output divider not a power");
   chk_mult_legal: assert property (
      outMultiplier_ff inside {11'h400, 11'h200, 11'h001})
      else $error("illegal multiplier");
   chk_byp_mult: assert property (
      s_byp |-> outMultiplier_ff == 11'h001)
      else $error("bypassed mode multiplies");
   chk_eng_mult: assert property (
      s_eng |-> outMultiplier_ff != 11'h001)
      else $error("engaged mode not multiplying");
   chk_rd_upper: assert property (
      s_axi_rvalid |-> s_axi_rdata[31:8] == 24'h000000)
      else $error("read data upper bits set");
   chk_rd_refuse: assert property (
      s_axi_rvalid |-> !s_axi_arready)
      else $error("read taken while answer pending");
endmodule : fms_clock_gen_asserts

bind fms_clock_gen fms_clock_gen_asserts u_chk (
   .clock(clock), .reset(reset), .debugEntryPin(debugEntryPin),
   .factoryTrim(factoryTrim), .s_axi_arready(s_axi_arready),
   .s_axi_rvalid(s_axi_rvalid), .s_axi_rdata(s_axi_rdata),
   .trimValue_ff(trimValue_ff), .outMultiplier_ff(outMultiplier_ff),
   .outDivider_ff(outDivider_ff), .busDivider_ff(busDivider_ff),
   .mode_ff(mode_ff)
);

/* File: fms_clock_gen_tb_top.sv */
// Self-checking bench for the clock generator.
`timescale 1ns/1ps

module fms_clock_gen_tb_top;
   logic        clock, reset, debugEntryPin, s_axi_awvalid, s_axi_awready;
   logic        s_axi_wvalid, s_axi_wready, s_axi_bvalid, s_axi_bready;
   logic        s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready;
   logic [1:0]  s_axi_bresp, s_axi_rresp;
   logic [3:0]  s_axi_wstrb, outDivider_ff;
   logic [4:0]  busDivider_ff;
   logic [7:0]  s_axi_awaddr, s_axi_araddr, d;
   logic [8:0]  factoryTrim, trimValue_ff;
   logic [10:0] outMultiplier_ff;
   logic [31:0] s_axi_wdata, s_axi_rdata, rdat;
   int          errors, num_checks, seed, i, mdl[5];
   fms_pkg::fms_mode_t mode_ff;

   fms_clock_gen #(.OSC_START_CYCLES(20)) dut (
      .clock(clock), .reset(reset), .debugEntryPin(debugEntryPin),
      .factoryTrim(factoryTrim), .s_axi_awvalid(s_axi_awvalid),
      .s_axi_awready(s_axi_awready), .s_axi_awaddr(s_axi_awaddr),
      .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready),
      .s_axi_wdata(s_axi_wdata), .s_axi_wstrb(s_axi_wstrb),
      .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready),
      .s_axi_bresp(s_axi_bresp), .s_axi_arvalid(s_axi_arvalid),
      .s_axi_arready(s_axi_arready), .s_axi_araddr(s_axi_araddr),
      .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready),
      .s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp),
      .trimValue_ff(trimValue_ff), .outMultiplier_ff(outMultiplier_ff),
      .outDivider_ff(outDivider_ff), .busDivider_ff(busDivider_ff),
      .mode_ff(mode_ff)
   );

   initial begin
      clock = 1'b0;
      forever #20 clock = ~clock;
   end

   task automatic close_out;
      $display("checks %0d errors %0d", num_checks, errors);
      if (errors == 0 && num_checks > 0) begin
         $display("No errors found");
      end else begin
         $display("Errors were found");
      end
      $finish;
   endtask : close_out

   task automatic chk(input string nm, input logic [31:0] s, e);
      num_checks++;
      if (s !== e) begin
         errors++;
         $display("mismatch %s expected %h seen %h", nm, e, s);
      end
   endtask : chk

   task automatic lapse;
      errors++;
      close_out();
   endtask : lapse

   // ------
   // Bus cycles
   // ------
   task automatic wr(input logic [7:0] a, v);
      int n;
      s_axi_awaddr <= a;
      s_axi_wdata <= {24'h000000, v};
      s_axi_awvalid <= 1'b1;
      s_axi_wvalid <= 1'b1;
      for (n = 0; n < 40; n++) begin
         @(posedge clock);
         if (s_axi_awready) s_axi_awvalid <= 1'b0;
         if (s_axi_wready) s_axi_wvalid <= 1'b0;
         if (s_axi_bvalid) break;
      end
      if (n == 40) lapse();
      chk("bresp", 32'(s_axi_bresp), a > 8'h10 ? 32'h2 : 32'h0);
      if (a <= 8'h10) mdl[a[4:2]] = int'(v);
   endtask : wr

   // Register reads are compared with the model, status on bit 0 only; unmapped reads check rresp only.
   task automatic rd(input logic [7:0] a);
      int n;
      s_axi_araddr <= a;
      s_axi_arvalid <= 1'b1;
      for (n = 0; n < 40; n++) begin
         @(posedge clock);
         if (s_axi_arready) s_axi_arvalid <= 1'b0;
         if (s_axi_rvalid) break;
      end
      if (n == 40) lapse();
      rdat = s_axi_rdata;
      if (a > 8'h10) chk("rresp", 32'(s_axi_rresp), 32'h2);
      else if (a == 8'h08) chk("fine", rdat & 1, 32'(mdl[2] & 1));
      else chk("reg", rdat, 32'(mdl[a[4:2]]));
   endtask : rd

   task automatic poll(input logic [31:0] m, v);
      int n;
      rd(8'h08);
      for (n = 0; n < 900 && (rdat & m) !== v; n++) rd(8'h08);
      if (n == 900) lapse();
      chk("status", rdat & m, v);
   endtask : poll

   initial begin
      seed = 21037;
      reset = 1'b1;
      debugEntryPin = 1'b0;
      factoryTrim = 9'($random(seed));
      {s_axi_awvalid, s_axi_wvalid, s_axi_arvalid} = 3'h0;
      {s_axi_awaddr, s_axi_araddr, s_axi_wdata} = 48'h0;
      {s_axi_bready, s_axi_rready, s_axi_wstrb} = 6'h3F;
      rdat = 32'hFFFFFFFF;
      repeat (8) @(posedge clock);
      reset <= 1'b0;
      mdl = '{4, 64, int'(factoryTrim[0]), 1, int'(factoryTrim[8:1])};
      repeat (10) @(posedge clock);
      chk("trim", 32'(trimValue_ff), 32'(factoryTrim));
      for (i = 0; i < 6; i++) rd(8'(i * 4));
      poll(32'h1E, 32'h10);
      wr(8'h00, 8'h5C);
      poll(32'h1C, 32'h14);
      wr(8'h04, 8'h08);
      @(posedge clock);
      chk("mode", 32'(mode_ff), 32'(fms_pkg::MODE_LOWPWR_INT));
      poll(32'h40, 32'h00);
      wr(8'h04, 8'h00);
      poll(32'h40, 32'h40);
      chk("mode", 32'(mode_ff), 32'(fms_pkg::MODE_FLL_BYP_INT));
      wr(8'h04, 8'h36);
      poll(32'h02, 32'h02);
      wr(8'h00, 8'h18);
      poll(32'h10, 32'h00);
      poll(32'h4C, 32'h40);
      chk("mult", 32'(outMultiplier_ff), 32'h400);
      chk("busdiv", 32'(busDivider_ff), 32'h2);
      chk("mode", 32'(mode_ff), 32'(fms_pkg::MODE_FLL_ENG_EXT));
      for (i = 3; i >= 0; i--) begin
         wr(8'h04, {2'(i), 6'h36});
         @(posedge clock);
         chk("outdiv", 32'(outDivider_ff), 32'(1 << i));
         chk("busdiv", 32'(busDivider_ff), 32'(2 << i));
      end
      for (i = 0; i < 2; i++) begin
         wr(8'h0C, 8'(i));
         poll(32'h40, 32'h40);
         chk("mult", 32'(outMultiplier_ff), i ? 32'h400 : 32'h200);
      end
      wr(8'h00, 8'h20);
      for (i = 0; i < 5; i++) begin
         d = (i == 4) ? 8'hFF : 8'($random(seed));
         wr(8'h10, d);
         wr(8'h08, {7'h00, d[1]});
         repeat (2) @(posedge clock);
         chk("trim", 32'(trimValue_ff), {23'h0, d, d[1]});
      end
      wr(8'h00, 8'h18);
      for (i = 0; i < 5; i++) rd(8'(i * 4));
      wr(8'h14, 8'hAA);
      debugEntryPin <= 1'b1;
      reset <= 1'b1;
      repeat (8) @(posedge clock);
      reset <= 1'b0;
      repeat (10) @(posedge clock);
      chk("trim", 32'(trimValue_ff), 32'h0);
      mdl = '{4, 64, 0, 1, 0};
      for (i = 0; i < 5; i++) rd(8'(i * 4));
      close_out();
   end
endmodule : fms_clock_gen_tb_top
